// ==== design/thermal_io_pkg.sv ====
// constants, register map and carrier types of the thermal i/o supervisor
// assumes a 20 MHz clock and temperatures in signed 0.1 degree steps
package thermal_io_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned FAST_PWM_HZ   = 4_500;
   localparam int unsigned SLOW_PWM_HZ   = 3;
   localparam int unsigned PWM_STEPS     = 256;
   localparam int unsigned SLOW_STEPS    = 16;
   localparam int unsigned RETRY_MS      = 100;
   localparam int unsigned FAST_DIV      = CLK_HZ / (FAST_PWM_HZ * PWM_STEPS);
   localparam int unsigned SLOW_DIV      = CLK_HZ / (SLOW_PWM_HZ * SLOW_STEPS);
   localparam int unsigned RETRY_CYCLES  = (CLK_HZ / 1000) * RETRY_MS;

   // register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_SETPOINT1 = 4'h1;
   localparam logic [3:0] REG_SETPOINT2 = 4'h2;
   localparam logic [3:0] REG_TOL_BAND  = 4'h3;
   localparam logic [3:0] REG_ALARM_BAND= 4'h4;
   localparam logic [3:0] REG_S2_LIMIT  = 4'h5;
   localparam logic [3:0] REG_S3_LIMIT  = 4'h6;
   localparam logic [3:0] REG_S2_TRIM   = 4'h7;
   localparam logic [3:0] REG_S3_TRIM   = 4'h8;
   localparam logic [3:0] REG_FAN_LIMIT = 4'h9;
   localparam logic [3:0] REG_FAN_HYST  = 4'hA;
   localparam logic [3:0] REG_DZ_BAND   = 4'hB;
   localparam logic [3:0] REG_DUTY      = 4'hC;
   localparam logic [3:0] REG_STATUS    = 4'hD;
   localparam logic [3:0] REG_TEMP2     = 4'hE;
   localparam logic [3:0] REG_TEMP3     = 4'hF;

   // status bit positions
   localparam int ST_E005     = 0;
   localparam int ST_E006     = 1;
   localparam int ST_OC_FLAG  = 2;
   localparam int ST_EXT_ERR  = 3;
   localparam int ST_POWER    = 4;
   localparam int ST_FAN      = 5;
   localparam int ST_STATUS   = 6;
   localparam int ST_POLARITY = 7;
   localparam int ST_OC_HOLD  = 8;

   typedef logic signed [15:0] temp_t;

   // temperature figures, 0.1 degree units
   localparam temp_t SENSOR_OFF   = 16'shFC19;   // -99.9
   localparam temp_t LIMIT_MIN    = 16'shFD12;   // -75.0
   localparam temp_t LIMIT_MAX    = 16'sh06D6;   // 175.0
   localparam temp_t TRIM_MIN     = 16'shFF9D;   // -9.9
   localparam temp_t TRIM_MAX     = 16'sh0063;   // +9.9
   localparam temp_t DUTY_MAX     = 16'sh00FF;
   localparam temp_t TRIM_RST     = 16'sh0000;
   localparam temp_t SETPOINT_RST = 16'sh00FA;
   localparam temp_t TOL_RST      = 16'sh000A;
   localparam temp_t ALARM_RST    = 16'sh0032;
   localparam temp_t FAN_LIM_RST  = 16'sh01F4;
   localparam temp_t FAN_HYST_RST = 16'sh0014;
   localparam temp_t DZ_BAND_RST  = 16'sh0000;

   typedef enum logic [1:0] {SENSOR_PT100, SENSOR_PT1000, SENSOR_USER} sensor_t;
   typedef enum logic [1:0] {AUX_FORCE_OFF, AUX_FORCE_ON, AUX_DUAL_SET} aux_mode_t;

   typedef struct packed {
      logic      deadZoneEn;
      logic      slowPwm;
      logic      heaterMode;
      aux_mode_t auxMode;
      logic      statusAlarm;
      sensor_t   sensorType;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{deadZoneEn: 1'b0, slowPwm: 1'b0, heaterMode: 1'b0,
                                  auxMode: AUX_FORCE_OFF, statusAlarm: 1'b0,
                                  sensorType: SENSOR_PT1000};

   typedef struct packed {
      temp_t temp1;
      temp_t temp2;
      temp_t temp3;
   } sense_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic              wr;
      logic              rd;
   } bus_req_t;

endpackage

// ==== design/power_pwm.sv ====
// power pwm generator: fast 256-step pwm or slow 16-step pwm
// assumes duty is a magnitude 0..255; slow mode uses its upper nibble
`timescale 1ns/1ps
module power_pwm #(
   parameter int unsigned FAST_DIV = thermal_io_pkg::FAST_DIV,
   parameter int unsigned SLOW_DIV = thermal_io_pkg::SLOW_DIV
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       slow,
   input  wire logic [7:0] duty,
   output logic            pwm
);
   localparam int PW = $clog2(SLOW_DIV + 1);

   typedef struct packed {
      logic [PW-1:0] pre;
      logic [7:0]    step;
      logic          slowSeen;
      logic          pwm;
   } pwm_state_t;

   pwm_state_t st_reg;
   pwm_state_t st_next;

   always_comb begin
      logic [PW-1:0] div;
      div = slow ? PW'(SLOW_DIV - 1) : PW'(FAST_DIV - 1);
      st_next = st_reg;
      st_next.slowSeen = slow;
      if (slow != st_reg.slowSeen) begin
         // restart the frame when the rate changes
         st_next.pre  = '0;
         st_next.step = '0;
      end else if (st_reg.pre >= div) begin
         st_next.pre  = '0;
         st_next.step = slow ? {4'h0, st_reg.step[3:0] + 4'h1} : st_reg.step + 8'h01;
      end else begin
         st_next.pre = st_reg.pre + PW'(1);
      end
      st_next.pwm = slow ? (st_reg.step[3:0] < duty[7:4]) : (st_reg.step < duty);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pwm = st_reg.pwm;
endmodule

// ==== design/thermal_io_supervisor.sv ====
// supervisory and output control of a temperature controller
// assumes readings already digitised and linearised, synchronous to mclk
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Operation
// - main sensor type selectable pt100, pt1000 or user; pt1000 after reset.
// - trimmed sensor 2 above its limit disables power and raises sensor 2 error.
// - sensor 2 limit in 0.1 degree, -75.0..175.0; -99.9 disables sensor 2.
// - trimmed sensor 3 above its limit disables power and raises sensor 3 error.
// - sensor 3 limit in 0.1 degree, -75.0..175.0; -99.9 disables sensor 3.
// - signed trims -9.9..+9.9, default 0.0, added to sensor 2 and 3.
// - trimmed sensor 2 drives the dead zone that suppresses power.
// - trimmed sensor 3 drives the fan decision.
// - ok semantics: status on while main temperature within tolerance of setpoint.
// - ok semantics: status also on inside dead zone with power off.
// - ok semantics: any pending error forces status off.
// - alarm semantics: status on while main temperature outside alarm band.
// - alarm semantics: any pending error forces status on.
// - force-off aux mode: active input holds power off.
// - force-on aux mode: power allowed only while input active.
// - dual aux mode: active input selects setpoint 2, else setpoint 1.
// - thermoelectric mode: about 4.5 kHz pwm, polarity follows heat or cool.
// - overcurrent shuts power off, then retries automatically.
// - heater mode: power fully off while temperature above setpoint.
// - heater mode with slow pwm: about 3 Hz, 16 steps; else fast pwm.
// - fan follows sensor 3 with limit and hysteresis, only if sensor 3 enabled.
// - sensor 3 error keeps fan on while power stays disabled.
// - pwm, polarity, power, fan and status outputs inactive during initialisation; power and pwm also inactive on detected errors.
module thermal_io_supervisor #(
   parameter int unsigned FAST_DIV     = thermal_io_pkg::FAST_DIV,
   parameter int unsigned SLOW_DIV     = thermal_io_pkg::SLOW_DIV,
   parameter int unsigned RETRY_CYCLES = thermal_io_pkg::RETRY_CYCLES
) (
   input  wire logic                            mclk,
   input  wire logic                            rst,
   input  wire thermal_io_pkg::bus_req_t        busReq,
   output logic [thermal_io_pkg::DATA_W-1:0]    rdData,
   input  wire thermal_io_pkg::sense_t          sense,
   input  wire logic                            auxIn,
   input  wire logic                            overCurrent,
   input  wire logic                            initBusy,
   input  wire logic                            extError,
   output logic                                 pwmOut,
   output logic                                 pwmPolarity,
   output logic                                 powerEnable,
   output logic                                 fanOn,
   output logic                                 statusOut,
   output thermal_io_pkg::sensor_t              sensorSel
);
   localparam int RW = $clog2(RETRY_CYCLES + 1);

   typedef struct packed {
      thermal_io_pkg::ctrl_t             ctrl;
      thermal_io_pkg::temp_t             setpoint1;
      thermal_io_pkg::temp_t             setpoint2;
      thermal_io_pkg::temp_t             tolBand;
      thermal_io_pkg::temp_t             alarmBand;
      thermal_io_pkg::temp_t             sensor2_trip_limit;
      thermal_io_pkg::temp_t             sensor3_trip_limit;
      thermal_io_pkg::temp_t             sensor2_trim;
      thermal_io_pkg::temp_t             sensor3_trim;
      thermal_io_pkg::temp_t             fanLimit;
      thermal_io_pkg::temp_t             fanHyst;
      thermal_io_pkg::temp_t             dzBand;
      thermal_io_pkg::temp_t             duty;
      logic                              err2;
      logic                              err3;
      logic                              ocFlag;
      logic                              ocHold;
      logic [RW-1:0]                     retryCnt;
      logic                              fanState;
      logic                              fanOn;
      logic                              powerOn;
      logic                              pwmOut;
      logic                              polarity;
      logic                              statusOut;
      logic [thermal_io_pkg::DATA_W-1:0] rdData;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic   pwmRaw;
   logic   [7:0] dutyMag;

   // |a - b| <= band, exact integer compare
   function automatic logic withinBand(input thermal_io_pkg::temp_t a,
                                       input thermal_io_pkg::temp_t b,
                                       input thermal_io_pkg::temp_t band);
      logic signed [16:0] d;
      d = 17'(a) - 17'(b);
      if (d < 0) begin
         d = -d;
      end
      return d <= 17'(band);
   endfunction

   // limit accepted only as the disable code or inside the span
   function automatic logic limitOk(input thermal_io_pkg::temp_t v);
      return (v == thermal_io_pkg::SENSOR_OFF) ||
             ((v >= thermal_io_pkg::LIMIT_MIN) && (v <= thermal_io_pkg::LIMIT_MAX));
   endfunction

   function automatic thermal_io_pkg::temp_t clampTrim(input thermal_io_pkg::temp_t v);
      if (v < thermal_io_pkg::TRIM_MIN) begin
         return thermal_io_pkg::TRIM_MIN;
      end
      if (v > thermal_io_pkg::TRIM_MAX) begin
         return thermal_io_pkg::TRIM_MAX;
      end
      return v;
   endfunction

   power_pwm #(
      .FAST_DIV (FAST_DIV),
      .SLOW_DIV (SLOW_DIV)
   ) u_pwm (
      .mclk (mclk),
      .rst  (rst),
      .slow (st_reg.ctrl.heaterMode && st_reg.ctrl.slowPwm),
      .duty (dutyMag),
      .pwm  (pwmRaw)
   );

   always_comb begin
      thermal_io_pkg::temp_t t2, t3, sp;
      logic s2En, s3En, over2, over3, inDz, anyErr, auxOk, heatOff, allow;
      logic [thermal_io_pkg::DATA_W-1:0] stat, w;
      logic signed [16:0] mag;
      t2 = thermal_io_pkg::temp_t'(sense.temp2 + st_reg.sensor2_trim);
      t3 = thermal_io_pkg::temp_t'(sense.temp3 + st_reg.sensor3_trim);
      s2En = st_reg.sensor2_trip_limit != thermal_io_pkg::SENSOR_OFF;
      s3En = st_reg.sensor3_trip_limit != thermal_io_pkg::SENSOR_OFF;
      over2 = s2En && (t2 > st_reg.sensor2_trip_limit);
      over3 = s3En && (t3 > st_reg.sensor3_trip_limit);
      sp = (st_reg.ctrl.auxMode == thermal_io_pkg::AUX_DUAL_SET && auxIn) ?
           st_reg.setpoint2 : st_reg.setpoint1;
      inDz = st_reg.ctrl.deadZoneEn && s2En &&
             withinBand(t2, sp, st_reg.dzBand);
      anyErr = st_reg.err2 || st_reg.err3 || st_reg.ocHold || extError;
      unique case (st_reg.ctrl.auxMode)
         thermal_io_pkg::AUX_FORCE_OFF: auxOk = !auxIn;
         thermal_io_pkg::AUX_FORCE_ON:  auxOk = auxIn;
         default:                       auxOk = 1'b1;
      endcase
      heatOff = st_reg.ctrl.heaterMode &&
                ((sense.temp1 > sp) || (st_reg.duty <= 0));
      allow = !initBusy && !anyErr && auxOk && !inDz && !heatOff;

      mag = 17'(st_reg.duty);
      if (mag < 0) begin
         mag = -mag;
      end
      if (mag > 17'(thermal_io_pkg::DUTY_MAX)) begin
         mag = 17'(thermal_io_pkg::DUTY_MAX);
      end

      st_next = st_reg;
      dutyMag = allow ? mag[7:0] : 8'h00;

      // sticky trips, set wins over a software clear
      w = busReq.wrData;
      if (busReq.wr && busReq.addr == thermal_io_pkg::REG_STATUS) begin
         if (w[thermal_io_pkg::ST_E005]) st_next.err2 = 1'b0;
         if (w[thermal_io_pkg::ST_E006]) st_next.err3 = 1'b0;
         if (w[thermal_io_pkg::ST_OC_FLAG]) st_next.ocFlag = 1'b0;
      end
      if (over2) st_next.err2 = 1'b1;
      if (over3) st_next.err3 = 1'b1;

      // overcurrent shut off and timed retry
      if (overCurrent) begin
         st_next.ocHold   = 1'b1;
         st_next.ocFlag   = 1'b1;
         st_next.retryCnt = RW'(RETRY_CYCLES - 1);
      end else if (st_reg.ocHold) begin
         if (st_reg.retryCnt == '0) begin
            st_next.ocHold = 1'b0;
         end else begin
            st_next.retryCnt = st_reg.retryCnt - RW'(1);
         end
      end

      // fan with hysteresis
      if (!s3En) begin
         st_next.fanState = 1'b0;
      end else if (t3 >= st_reg.fanLimit) begin
         st_next.fanState = 1'b1;
      end else if (17'(t3) < 17'(st_reg.fanLimit) - 17'(st_reg.fanHyst)) begin
         st_next.fanState = 1'b0;
      end
      if (initBusy) begin
         st_next.fanOn = 1'b0;
      end else if (st_reg.err3) begin
         st_next.fanOn = 1'b1;
      end else begin
         st_next.fanOn = st_reg.fanState && !anyErr;
      end

      // power stage
      st_next.powerOn  = allow;
      st_next.pwmOut   = pwmRaw && allow;
      st_next.polarity = allow && !st_reg.ctrl.heaterMode &&
                         (st_reg.duty < 0);

      // process status output
      if (initBusy) begin
         st_next.statusOut = 1'b0;
      end else if (st_reg.ctrl.statusAlarm) begin
         st_next.statusOut = anyErr ||
                             !withinBand(sense.temp1, sp, st_reg.alarmBand);
      end else begin
         st_next.statusOut = !anyErr &&
                             (withinBand(sense.temp1, sp, st_reg.tolBand) ||
                              (inDz && !st_reg.powerOn));
      end

      // register writes
      if (busReq.wr) begin
         unique case (busReq.addr)
            thermal_io_pkg::REG_CTRL:       st_next.ctrl = thermal_io_pkg::ctrl_t'(w[7:0]);
            thermal_io_pkg::REG_SETPOINT1:  st_next.setpoint1 = w;
            thermal_io_pkg::REG_SETPOINT2:  st_next.setpoint2 = w;
            thermal_io_pkg::REG_TOL_BAND:   st_next.tolBand = w;
            thermal_io_pkg::REG_ALARM_BAND: st_next.alarmBand = w;
            thermal_io_pkg::REG_S2_LIMIT: begin
               if (limitOk(w)) st_next.sensor2_trip_limit = w;
            end
            thermal_io_pkg::REG_S3_LIMIT: begin
               if (limitOk(w)) st_next.sensor3_trip_limit = w;
            end
            thermal_io_pkg::REG_S2_TRIM:    st_next.sensor2_trim = clampTrim(w);
            thermal_io_pkg::REG_S3_TRIM:    st_next.sensor3_trim = clampTrim(w);
            thermal_io_pkg::REG_FAN_LIMIT:  st_next.fanLimit = w;
            thermal_io_pkg::REG_FAN_HYST:   st_next.fanHyst = w;
            thermal_io_pkg::REG_DZ_BAND:    st_next.dzBand = w;
            thermal_io_pkg::REG_DUTY:       st_next.duty = w;
            default: ;
         endcase
      end

      // register reads, data in the following cycle
      stat = '0;
      stat[thermal_io_pkg::ST_E005]     = st_reg.err2;
      stat[thermal_io_pkg::ST_E006]     = st_reg.err3;
      stat[thermal_io_pkg::ST_OC_FLAG]  = st_reg.ocFlag;
      stat[thermal_io_pkg::ST_EXT_ERR]  = extError;
      stat[thermal_io_pkg::ST_POWER]    = st_reg.powerOn;
      stat[thermal_io_pkg::ST_FAN]      = st_reg.fanOn;
      stat[thermal_io_pkg::ST_STATUS]   = st_reg.statusOut;
      stat[thermal_io_pkg::ST_POLARITY] = st_reg.polarity;
      stat[thermal_io_pkg::ST_OC_HOLD]  = st_reg.ocHold;
      st_next.rdData = '0;
      if (busReq.rd) begin
         unique case (busReq.addr)
            thermal_io_pkg::REG_CTRL:       st_next.rdData = {8'h00, st_reg.ctrl};
            thermal_io_pkg::REG_SETPOINT1:  st_next.rdData = st_reg.setpoint1;
            thermal_io_pkg::REG_SETPOINT2:  st_next.rdData = st_reg.setpoint2;
            thermal_io_pkg::REG_TOL_BAND:   st_next.rdData = st_reg.tolBand;
            thermal_io_pkg::REG_ALARM_BAND: st_next.rdData = st_reg.alarmBand;
            thermal_io_pkg::REG_S2_LIMIT:   st_next.rdData = st_reg.sensor2_trip_limit;
            thermal_io_pkg::REG_S3_LIMIT:   st_next.rdData = st_reg.sensor3_trip_limit;
            thermal_io_pkg::REG_S2_TRIM:    st_next.rdData = st_reg.sensor2_trim;
            thermal_io_pkg::REG_S3_TRIM:    st_next.rdData = st_reg.sensor3_trim;
            thermal_io_pkg::REG_FAN_LIMIT:  st_next.rdData = st_reg.fanLimit;
            thermal_io_pkg::REG_FAN_HYST:   st_next.rdData = st_reg.fanHyst;
            thermal_io_pkg::REG_DZ_BAND:    st_next.rdData = st_reg.dzBand;
            thermal_io_pkg::REG_DUTY:       st_next.rdData = st_reg.duty;
            thermal_io_pkg::REG_STATUS:     st_next.rdData = stat;
            thermal_io_pkg::REG_TEMP2:      st_next.rdData = t2;
            thermal_io_pkg::REG_TEMP3:      st_next.rdData = t3;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg                    <= '0;
         st_reg.ctrl               <= thermal_io_pkg::CTRL_RST;
         st_reg.setpoint1          <= thermal_io_pkg::SETPOINT_RST;
         st_reg.setpoint2          <= thermal_io_pkg::SETPOINT_RST;
         st_reg.tolBand            <= thermal_io_pkg::TOL_RST;
         st_reg.alarmBand          <= thermal_io_pkg::ALARM_RST;
         st_reg.sensor2_trip_limit <= thermal_io_pkg::SENSOR_OFF;
         st_reg.sensor3_trip_limit <= thermal_io_pkg::SENSOR_OFF;
         st_reg.sensor2_trim       <= thermal_io_pkg::TRIM_RST;
         st_reg.sensor3_trim       <= thermal_io_pkg::TRIM_RST;
         st_reg.fanLimit           <= thermal_io_pkg::FAN_LIM_RST;
         st_reg.fanHyst            <= thermal_io_pkg::FAN_HYST_RST;
         st_reg.dzBand             <= thermal_io_pkg::DZ_BAND_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdData      = st_reg.rdData;
   assign pwmOut      = st_reg.pwmOut;
   assign pwmPolarity = st_reg.polarity;
   assign powerEnable = st_reg.powerOn;
   assign fanOn       = st_reg.fanOn;
   assign statusOut   = st_reg.statusOut;
   assign sensorSel   = st_reg.ctrl.sensorType;
endmodule

// ==== tb/thermal_io_supervisor_sva.sv ====
// concurrent checks on the supervisor's ports
// assumes a single mclk domain with async active high rst
`timescale 1ns/1ps
module thermal_io_supervisor_sva (
   input wire logic                              mclk,
   input wire logic                              rst,
   input wire thermal_io_pkg::bus_req_t          busReq,
   input wire logic [thermal_io_pkg::DATA_W-1:0] rdData,
   input wire thermal_io_pkg::sense_t            sense,
   input wire logic                              auxIn,
   input wire logic                              overCurrent,
   input wire logic                              initBusy,
   input wire logic                              extError,
   input wire logic                              pwmOut,
   input wire logic                              pwmPolarity,
   input wire logic                              powerEnable,
   input wire logic                              fanOn,
   input wire logic                              statusOut,
   input wire thermal_io_pkg::sensor_t           sensorSel
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_init_power_off: assert property (initBusy |=> !powerEnable)
      else $error("power enabled during init");
   a_init_fan_off: assert property (initBusy |=> !fanOn)
      else $error("fan on during init");
   a_init_status_off: assert property (initBusy |=> !statusOut)
      else $error("status on during init");
   a_init_pwm_off: assert property (initBusy [*2] |=> !pwmOut)
      else $error("pwm active during init");
   a_error_power_off: assert property (extError |=> !powerEnable)
      else $error("power enabled with pending error");
   a_oc_shutdown: assert property (overCurrent |-> ##3 !powerEnable [*8])
      else $error("power not held off after overcurrent");
   a_pwm_gated: assert property (pwmOut |-> powerEnable || $past(powerEnable))
      else $error("pwm active without power enable");
   a_ctrl_holds_sel: assert property
      (!(busReq.wr && busReq.addr == thermal_io_pkg::REG_CTRL) |=> $stable(sensorSel))
      else $error("sensor type changed without control write");
   c_oc_trip: cover property (overCurrent ##3 !powerEnable);
   c_fan_err: cover property (fanOn && !powerEnable);
   c_status_rise: cover property ($rose(statusOut));
endmodule
bind thermal_io_supervisor thermal_io_supervisor_sva i_sva (.mclk, .rst, .busReq, .rdData,
   .sense, .auxIn, .overCurrent, .initBusy, .extError, .pwmOut, .pwmPolarity, .powerEnable,
   .fanOn, .statusOut, .sensorSel);

// ==== tb/power_stage_model.sv ====
// stand-in for the power stage with a commanded load fault
// assumes fault is driven off the clock edge by the bench
`timescale 1ns/1ps
module power_stage_model (
   input  wire logic mclk,
   input  wire logic pwmOut,
   input  wire logic powerEnable,
   input  wire logic fault,
   output logic      overCurrent = 1'h0
);
   // a shorted load only trips while the stage conducts
   always @(posedge mclk)
      overCurrent <= fault && pwmOut && powerEnable;
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the thermal i/o supervisor
// assumes shortened pwm and retry counts given at the instance
`timescale 1ns/1ps
module tb;
   logic mclk = 1'h0, rst = 1'h1, auxIn = 1'h0, initBusy = 1'h0, extError = 1'h0;
   logic fault = 1'h0, rdSeen = 1'h0, overCurrent;
   logic pwmOut, pwmPolarity, powerEnable, fanOn, statusOut;
   logic [15:0] rdData, t, lfsr = 16'h2F44;
   logic [31:0] e;
   logic [31:0] expQ[$];
   logic [15:0] rstVal [16] = '{16'h0001, 16'h00FA, 16'h00FA, 16'h000A, 16'h0032, 16'hFC19,
      16'hFC19, 16'h0000, 16'h0000, 16'h01F4, 16'h0014, 16'h0000, 16'h0000, 16'h0010, 16'h0000,
      16'h0000};
   logic [15:0] lim [8][3] = '{'{16'h7, 16'h00C8, 16'h0063}, '{16'h8, 16'hFF38, 16'hFF9D},
      '{16'h5, 16'h06D7, 16'hFC19}, '{16'h5, 16'hFD11, 16'hFC19}, '{16'h5, 16'hFD12, 16'hFD12},
      '{16'h5, 16'h06D6, 16'h06D6}, '{16'h6, 16'h06D6, 16'h06D6}, '{16'h6, 16'hFC19, 16'hFC19}};
   logic [15:0] fanT [4] = '{16'h01C1, 16'h01B2, 16'h01AC, 16'h01F4};
   logic [15:0] fanE [4] = '{16'h0030, 16'h0030, 16'h0010, 16'h0022};
   thermal_io_pkg::bus_req_t busReq = '0;
   thermal_io_pkg::sense_t   sense = '0;
   thermal_io_pkg::sensor_t  sensorSel;
   int miscompares = 0, check_count = 0, i;
   thermal_io_supervisor #(.FAST_DIV(1), .SLOW_DIV(2), .RETRY_CYCLES(20))
      i_thermal_io_supervisor (.mclk, .rst, .busReq, .rdData, .sense, .auxIn, .overCurrent,
      .initBusy, .extError, .pwmOut, .pwmPolarity, .powerEnable, .fanOn, .statusOut, .sensorSel);
   power_stage_model i_power_stage_model (.mclk, .pwmOut, .powerEnable, .fault, .overCurrent);
   initial forever #25 mclk = ~mclk;
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      busReq <= '{addr: a[3:0], wrData: d, wr: 1'h1, rd: 1'h0};
      @(posedge mclk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic [15:0] m = 16'hFFFF);
      busReq <= '{addr: a[3:0], wrData: 16'h0000, wr: 1'h0, rd: 1'h1};
      expQ.push_back({m, x});
      @(posedge mclk);
   endtask
   task automatic idle(input int n);
      busReq <= '0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic probe(input logic [15:0] t1, input logic [15:0] x, input logic [15:0] m = 16'h0050);
      sense.temp1 <= t1;
      idle(2);
      rd(16'hD, x, m);
   endtask
   task automatic tdone(input string s);
      idle(3);
      $display("test %s done", s);
   endtask
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      rdSeen <= busReq.rd;
      if (rdSeen) begin
         e = expQ.pop_front();
         check_count++;
         if (((rdData ^ e[15:0]) & e[31:16]) !== 16'h0000) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, rdData, e[15:0]);
         end
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      for (i = 0; i < 16; i++) rd(i, rstVal[i]);
      for (i = 0; i < 8; i++) begin
         wr(lim[i][0], lim[i][1]);
         rd(lim[i][0], lim[i][2]);
      end
      wr(16'hD, 16'h0007);
      tdone("limits");
      wr(16'h7, 16'h0005);
      wr(16'h5, 16'h012C);
      sense.temp2 <= 16'h0127;
      idle(3);
      rd(16'hE, 16'h012C);
      rd(16'hD, 16'h0010, 16'h0013);
      sense.temp2 <= 16'h0128;
      idle(3);
      rd(16'hD, 16'h0001, 16'h0013);
      sense.temp2 <= 16'h0000;
      idle(2);
      wr(16'hD, 16'h0007);
      wr(16'h9, 16'h015E);
      wr(16'h6, 16'h0190);
      for (i = 0; i < 4; i++) begin
         sense.temp3 <= fanT[i];
         idle(2);
         rd(16'hD, fanE[i], 16'h0033);
      end
      sense.temp3 <= 16'h0000;
      idle(2);
      wr(16'hD, 16'h0007);
      tdone("sensors");
      for (i = 0; i < 6; i++) begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         t = 16'h00EA + lfsr[4:0];
         probe(t, (t >= 16'h00F0 && t <= 16'h0104) ? 16'h0050 : 16'h0010);
      end
      wr(16'h0, 16'h0005);
      probe(16'h012C, 16'h0010);
      probe(16'h012D, 16'h0050);
      probe(16'h00C7, 16'h0050);
      extError <= 1'h1;
      probe(16'h00FA, 16'h0040);
      wr(16'h0, 16'h0001);
      probe(16'h00FA, 16'h0000);
      extError <= 1'h0;
      initBusy <= 1'h1;
      probe(16'h00FA, 16'h0000, 16'h0070);
      initBusy <= 1'h0;
      tdone("status");
      auxIn <= 1'h1;
      probe(16'h00FA, 16'h0040);
      wr(16'h0, 16'h0009);
      auxIn <= 1'h0;
      probe(16'h00FA, 16'h0040);
      auxIn <= 1'h1;
      probe(16'h00FA, 16'h0050);
      wr(16'h2, 16'h0190);
      wr(16'h0, 16'h0011);
      probe(16'h0190, 16'h0050);
      auxIn <= 1'h0;
      probe(16'h0190, 16'h0010);
      wr(16'hB, 16'h000A);
      wr(16'h0, 16'h0081);
      sense.temp2 <= 16'h00F5;
      probe(16'h0190, 16'h0040);
      sense.temp2 <= 16'h0000;
      tdone("aux");
      wr(16'h0, 16'h0021);
      wr(16'hC, 16'h0064);
      probe(16'h00FB, 16'h0000, 16'h0010);
      probe(16'h00F9, 16'h0010, 16'h0010);
      wr(16'h0, 16'h0061);
      fault <= 1'h1;
      for (i = 0; i < 400 && powerEnable !== 1'h0; i++) @(posedge mclk);
      if (i == 400) begin
         miscompares++;
         close_out();
      end
      fault <= 1'h0;
      rd(16'hD, 16'h0104, 16'h0114);
      idle(40);
      rd(16'hD, 16'h0014, 16'h0114);
      wr(16'h0, 16'h0001);
      wr(16'hC, 16'hFF9C);
      probe(16'h00FA, 16'h0080, 16'h0080);
      tdone("power");
      close_out();
   end
endmodule
